/* File: rtl/nfps_ctrl.v */
// host controller issuing flash command sequences and status polls
//
// Operation
// RL1 - program: three unlock writes, then address/data
// RL2 - chip erase: six writes ending 10
// RL3 - sector erase: sixth write 30 at sector
// RL4 - device accumulates sectors for 50us window
// RL5 - device restarts window per sector command
// RL6 - other command in window aborts erase
// RL7 - running erase accepts only suspend
// RL8 - suspend B0, resume 30, any address
// RL9 - query entry: 98 to 55 or AA
// RL10 - resume only valid when erase suspended
// RL11 - programming only clears bits to zero
// RL12 - device ignores commands while programming
// RL13 - program status: bit7 complement, bit6 toggles
// RL14 - protected program aborts within 1us
// RL15 - erase window bit shows window versus erasing
// RL16 - protected-only erase aborts within 100us
// RL17 - sector toggle bit marks sectors being erased
// RL18 - chip erase accepts no command
// RL19 - suspend ends window, or waits recovery time
// RL20 - suspended erase allows other sector access
// RL21 - host resumes and checks toggle before erasing
// RL22 - host writes only defined command codes
// RL23 - ready_busy_n low while operation active
// RL24 - toggle bit changes each read while busy
//
// Chosen here: register access over Avalon-MM and the address map.
`timescale 1ns/10ps
`include "nfps_map.vh"
module nfps_ctrl (
  // clock and reset
  input wire i_clock,
  input wire i_rst_b,
  // avalon-mm slave
  input wire [3:0] i_avs_address,
  input wire i_avs_read,
  input wire i_avs_write,
  input wire [31:0] i_avs_writedata,
  output wire [31:0] o_avs_readdata,
  output wire o_avs_waitrequest,
  // flash bus
  output wire [20:0] o_fl_addr,
  input wire [15:0] i_fl_dq,
  output wire [15:0] o_fl_dq,
  output wire o_fl_dq_oe,
  output wire o_fl_ce_n,
  output wire o_fl_we_n,
  output wire o_fl_oe_n,
  output wire o_fl_byte_n,
  input wire i_fl_ready_busy_n
);
  // ==========================================================
  // state
  localparam ST_IDLE = 3'h0;
  localparam ST_SET = 3'h1;
  localparam ST_PUL = 3'h2;
  localparam ST_HLD = 3'h3;
  localparam ST_RD = 3'h4;
  reg [2:0] st_r;
  reg [2:0] st_nxt;
  reg [7:0] cnt_r;
  reg [2:0] step_r;
  reg [2:0] op_r;
  reg byte_r;
  reg [20:0] addr_r;
  reg [15:0] data_r;
  reg [15:0] rdata_r;
  reg [15:0] prev_r;
  reg toggled_r;
  reg busy_op_r;
  reg [20:0] fa_r;
  reg [15:0] fd_r;
  reg ce_n_r;
  reg we_n_r;
  reg oe_n_r;
  reg oe_r;
  reg ack_r;
  reg [31:0] rd_r;
  wire [15:0] dq_s;
  wire rb_s;
  // ==========================================================
  // pin synchronisers
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi = gi + 1) begin : g_dq
      nfps_sync u_dq (
        .i_clock(i_clock),
        .i_rst_b(i_rst_b),
        .i_d(i_fl_dq[gi]),
        .o_q(dq_s[gi])
      );
    end
  endgenerate
  nfps_sync u_rb (
    .i_clock(i_clock),
    .i_rst_b(i_rst_b),
    .i_d(i_fl_ready_busy_n),
    .o_q(rb_s)
  );
  // ==========================================================
  // sequence table: number of cycles and each cycle's content
  reg [2:0] nsteps;
  reg [20:0] seq_a;
  reg [7:0] seq_d;
  reg seq_full;
  wire [20:0] a555 = byte_r ? `NFPS_A_B555 : `NFPS_A_W555;
  wire [20:0] a2aa = byte_r ? `NFPS_A_B2AA : `NFPS_A_W2AA;
  always @* begin
    nsteps = 3'h1;
    seq_a = a555;
    seq_d = `NFPS_D_UNL1;
    seq_full = 1'b0;
    case (op_r)
      `NFPS_OP_PROG: begin
        nsteps = 3'h4; // [RL1]
        case (step_r)
          3'h0: seq_d = `NFPS_D_UNL1;
          3'h1: begin
            seq_a = a2aa;
            seq_d = `NFPS_D_UNL2;
          end
          3'h2: seq_d = `NFPS_D_PROG;
          default: begin
            seq_a = addr_r;
            seq_full = 1'b1; // [RL11]
          end
        endcase
      end
      `NFPS_OP_CHIP, `NFPS_OP_SECT: begin
        nsteps = 3'h6; // [RL2] [RL3]
        case (step_r)
          3'h0, 3'h3: seq_d = `NFPS_D_UNL1;
          3'h1, 3'h4: begin
            seq_a = a2aa;
            seq_d = `NFPS_D_UNL2;
          end
          3'h2: seq_d = `NFPS_D_ERA;
          default: begin
            if (op_r == `NFPS_OP_SECT) begin
              seq_a = addr_r;
              seq_d = `NFPS_D_SECT; // [RL3]
            end else begin
              seq_d = `NFPS_D_CHIP; // [RL2]
            end
          end
        endcase
      end
      `NFPS_OP_SUSP: begin
        seq_a = addr_r;
        seq_d = `NFPS_D_SUSP; // [RL8]
      end
      `NFPS_OP_RESM: begin
        seq_a = addr_r;
        seq_d = `NFPS_D_RESM; // [RL8] [RL21]
      end
      `NFPS_OP_CFI: begin
        seq_a = byte_r ? `NFPS_A_BCFI : `NFPS_A_WCFI; // [RL9]
        seq_d = `NFPS_D_CFI;
      end
      `NFPS_OP_RST: begin
        seq_a = addr_r;
        seq_d = `NFPS_D_RESET;
      end
      default: seq_a = addr_r;
    endcase
  end
  // ==========================================================
  // bus decode; only defined codes reach the flash
  wire wr_take = i_avs_write && ack_r; // act only at the accepting edge
  wire wr_ctrl = wr_take && (i_avs_address == `NFPS_REG_CTRL);
  wire go = wr_ctrl && i_avs_writedata[`NFPS_CTRL_GO] &&
    (st_r == ST_IDLE); // [RL22]
  wire is_read = (op_r == `NFPS_OP_READ);
  always @* begin
    st_nxt = st_r;
    case (st_r)
      ST_IDLE: if (go) st_nxt = ST_SET;
      ST_SET: if (cnt_r == 8'h00) st_nxt = is_read ? ST_RD : ST_PUL;
      ST_PUL: if (cnt_r == 8'h00) st_nxt = ST_HLD;
      ST_HLD: if (cnt_r == 8'h00)
        st_nxt = (step_r + 3'h1 >= nsteps) ? ST_IDLE : ST_SET;
      ST_RD: if (cnt_r == 8'h00) st_nxt = ST_IDLE;
      default: st_nxt = ST_IDLE;
    endcase
  end
  always @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_r <= ST_IDLE;
      cnt_r <= 8'h00;
      step_r <= 3'h0;
      op_r <= 3'h0;
      byte_r <= 1'b0;
      addr_r <= 21'h000000;
      data_r <= 16'h0000;
      rdata_r <= 16'h0000;
      prev_r <= 16'h0000;
      toggled_r <= 1'b0;
      busy_op_r <= 1'b0;
      fa_r <= 21'h000000;
      fd_r <= 16'h0000;
      ce_n_r <= 1'b1;
      we_n_r <= 1'b1;
      oe_n_r <= 1'b1;
      oe_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      if (wr_take && st_r == ST_IDLE) begin
        if (i_avs_address == `NFPS_REG_ADDR)
          addr_r <= i_avs_writedata[20:0];
        if (i_avs_address == `NFPS_REG_DATA)
          data_r <= i_avs_writedata[15:0];
      end
      if (go) begin
        op_r <= i_avs_writedata[`NFPS_CTRL_CMD_MSB:`NFPS_CTRL_CMD_LSB];
        byte_r <= i_avs_writedata[`NFPS_CTRL_BYTE];
        step_r <= 3'h0;
        cnt_r <= `NFPS_T_SETUP;
        if (i_avs_writedata[`NFPS_CTRL_CMD_MSB:`NFPS_CTRL_CMD_LSB] !=
            `NFPS_OP_READ)
          busy_op_r <= 1'b1;
      end else if (cnt_r != 8'h00) begin
        cnt_r <= cnt_r - 8'h01;
      end
      case (st_r)
        ST_SET: begin
          fa_r <= seq_a;
          fd_r <= seq_full ? data_r : {8'h00, seq_d};
          ce_n_r <= 1'b0;
          oe_r <= !is_read;
          oe_n_r <= !is_read;
          if (cnt_r == 8'h00) begin
            we_n_r <= is_read;
            cnt_r <= is_read ? `NFPS_T_READ : `NFPS_T_PULSE;
          end
        end
        ST_PUL: begin
          if (cnt_r == 8'h00) begin
            we_n_r <= 1'b1; // data latched on rising write strobe
            cnt_r <= `NFPS_T_HOLD;
          end
        end
        ST_HLD: begin
          if (cnt_r == 8'h00) begin
            step_r <= step_r + 3'h1;
            cnt_r <= `NFPS_T_SETUP;
            ce_n_r <= 1'b1;
            oe_r <= 1'b0;
          end
        end
        ST_RD: begin
          if (cnt_r == 8'h00) begin
            // status poll: bit 6 change against last read means busy
            rdata_r <= dq_s;
            prev_r <= rdata_r;
            toggled_r <= (dq_s[6] != rdata_r[6]); // [RL24] [RL13]
            ce_n_r <= 1'b1;
            oe_n_r <= 1'b1;
          end
        end
        default: begin
          ce_n_r <= 1'b1;
          we_n_r <= 1'b1;
          oe_n_r <= 1'b1;
          oe_r <= 1'b0;
        end
      endcase
      if (rb_s && st_r == ST_IDLE && !go)
        busy_op_r <= 1'b0; // [RL23]
    end
  end
  // ==========================================================
  // register reads, one wait cycle each
  always @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ack_r <= 1'b0;
      rd_r <= 32'h00000000;
    end else begin
      ack_r <= o_avs_waitrequest;
      case (i_avs_address)
        `NFPS_REG_CTRL: rd_r <= {21'h000000, op_r, 3'h0, byte_r,
          3'h0, (st_r != ST_IDLE)};
        `NFPS_REG_ADDR: rd_r <= {11'h000, addr_r};
        `NFPS_REG_DATA: rd_r <= {prev_r, rdata_r};
        `NFPS_REG_STAT: rd_r <= {28'h0000000, toggled_r,
          busy_op_r, rb_s, (st_r != ST_IDLE)}; // [RL23]
        default: rd_r <= 32'h00000000;
      endcase
    end
  end
  assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !ack_r;
  assign o_avs_readdata = rd_r;
  assign o_fl_addr = fa_r;
  assign o_fl_dq = fd_r;
  assign o_fl_dq_oe = oe_r;
  assign o_fl_ce_n = ce_n_r;
  assign o_fl_we_n = we_n_r;
  assign o_fl_oe_n = oe_n_r;
  assign o_fl_byte_n = !byte_r;
endmodule

/* File: rtl/nfps_map.vh */
// constants for the flash command sequencer controller
`ifndef NFPS_MAP_VH
`define NFPS_MAP_VH
// host-side register offsets (byte addresses, one word each)
`define NFPS_REG_CTRL 4'h0
`define NFPS_REG_ADDR 4'h4
`define NFPS_REG_DATA 4'h8
`define NFPS_REG_STAT 4'hc
// control field positions
`define NFPS_CTRL_GO 0
`define NFPS_CTRL_BYTE 4
`define NFPS_CTRL_CMD_LSB 8
`define NFPS_CTRL_CMD_MSB 10
// operation codes
`define NFPS_OP_PROG 3'h0
`define NFPS_OP_CHIP 3'h1
`define NFPS_OP_SECT 3'h2
`define NFPS_OP_SUSP 3'h3
`define NFPS_OP_RESM 3'h4
`define NFPS_OP_CFI 3'h5
`define NFPS_OP_READ 3'h6
`define NFPS_OP_RST 3'h7
// flash command bytes
`define NFPS_D_UNL1 8'haa
`define NFPS_D_UNL2 8'h55
`define NFPS_D_PROG 8'ha0
`define NFPS_D_ERA 8'h80
`define NFPS_D_CHIP 8'h10
`define NFPS_D_SECT 8'h30
`define NFPS_D_SUSP 8'hb0
`define NFPS_D_RESM 8'h30
`define NFPS_D_CFI 8'h98
`define NFPS_D_RESET 8'hf0
// flash unlock and query addresses, word and byte mode
`define NFPS_A_W555 21'h000555
`define NFPS_A_W2AA 21'h0002aa
`define NFPS_A_B555 21'h000aaa
`define NFPS_A_B2AA 21'h000555
`define NFPS_A_WCFI 21'h000055
`define NFPS_A_BCFI 21'h0000aa
// bus cycle timing in clocks
`define NFPS_T_SETUP 8'h04
`define NFPS_T_PULSE 8'h0c
`define NFPS_T_HOLD 8'h04
`define NFPS_T_READ 8'h1c
// reset values
`define NFPS_RST_CTRL 32'h00000000
`endif

/* File: rtl/nfps_sync.v */
// two flip-flop synchroniser for one pin
`timescale 1ns/10ps
module nfps_sync (
  // clock and reset
  input wire i_clock,
  input wire i_rst_b,
  // pin and synchronised level
  input wire i_d,
  output wire o_q
);
  reg s1_r;
  reg s2_r;
  always @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
    end else begin
      s1_r <= i_d;
      s2_r <= s1_r;
    end
  end
  assign o_q = s2_r;
endmodule

/* File: test/nfps_ctrl_assertions.sv */
// checker for the flash controller's register bus and pin timing
`timescale 1ns/10ps
module nfps_ctrl_checker (
  // clock, reset and register bus
  input wire i_clock,
  input wire i_rst_b,
  input wire [3:0] i_avs_address,
  input wire i_avs_read,
  input wire i_avs_write,
  input wire [31:0] o_avs_readdata,
  input wire o_avs_waitrequest,
  // flash bus
  input wire [20:0] o_fl_addr,
  input wire [15:0] o_fl_dq,
  input wire o_fl_dq_oe,
  input wire o_fl_ce_n,
  input wire o_fl_we_n,
  input wire o_fl_oe_n
);
  wire req = i_avs_read | i_avs_write;
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);
  // ==========================================
  // assertions
  AST_WAIT_FIRST: assert property ($rose(req) |-> o_avs_waitrequest)
    else $error("no wait state in first access cycle");
  AST_WAIT_ONE: assert property (req && o_avs_waitrequest |=>
    !o_avs_waitrequest) else $error("access not answered in second cycle");
  AST_UNMAPPED: assert property (i_avs_read && i_avs_address == 4'h1 &&
    !o_avs_waitrequest |-> o_avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  AST_WE_QUAL: assert property (!o_fl_we_n |-> !o_fl_ce_n && o_fl_oe_n &&
    o_fl_dq_oe) else $error("write strobe without select or data");
  AST_NO_CONTEND: assert property (!o_fl_oe_n |-> !o_fl_dq_oe && !o_fl_ce_n)
    else $error("controller drives data during a read");
  AST_WE_PULSE: assert property ($fell(o_fl_we_n) |-> ##12 !o_fl_we_n ##1
    o_fl_we_n) else $error("write strobe not 13 cycles");
  AST_SETUP: assert property ($fell(o_fl_we_n) |->
    $past(o_fl_ce_n, 4) == 1'b0) else $error("select setup too short");
  AST_HOLD: assert property ($rose(o_fl_we_n) |-> !o_fl_ce_n[*3])
    else $error("select hold too short");
  AST_WR_STABLE: assert property (!o_fl_we_n && !$past(o_fl_we_n) |->
    $stable(o_fl_addr) && $stable(o_fl_dq))
    else $error("address or data moved under strobe");
  COV_TAKEN: cover property (req && !o_avs_waitrequest);
  COV_WRITE: cover property ($fell(o_fl_we_n));
  COV_READ: cover property ($fell(o_fl_oe_n));
endmodule
bind nfps_ctrl nfps_ctrl_checker chk_u (.i_clock(i_clock),
  .i_rst_b(i_rst_b), .i_avs_address(i_avs_address),
  .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
  .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
  .o_fl_addr(o_fl_addr), .o_fl_dq(o_fl_dq), .o_fl_dq_oe(o_fl_dq_oe),
  .o_fl_ce_n(o_fl_ce_n), .o_fl_we_n(o_fl_we_n), .o_fl_oe_n(o_fl_oe_n));

/* File: test/nfps_flash_model.sv */
// behavioural flash device on the controller's far side
`timescale 1ns/10ps
module nfps_flash_model #(
  parameter int PROG = 300,
  parameter int WIN = 600,
  parameter int ERA = 1500,
  parameter int REC = 40,
  parameter int ABT = 20
) (
  // flash pins
  input wire i_clock,
  input wire [20:0] i_addr,
  input wire [15:0] i_dq,
  input wire i_ce_n,
  input wire i_we_n,
  input wire i_oe_n,
  input wire i_byte_n,
  output logic [15:0] o_dq,
  output wire o_rdy
);
  logic [15:0] mem [0:255];
  logic [15:0] pd = 16'h0;
  logic [15:0] last = 16'h0;
  logic we_q = 1, oe_q = 1, tog = 0, cfi = 0, chip = 0;
  int step = 0, mode = 0, cnt = 0;
  wire [7:0] d = i_dq[7:0];
  wire [20:0] u1 = i_byte_n ? 21'h555 : 21'haaa;
  wire [20:0] u2 = i_byte_n ? 21'h2aa : 21'h555;
  wire [20:0] cfa = i_byte_n ? 21'h55 : 21'haa;
  wire busy = mode > 0 && mode < 5;
  wire rd = !i_ce_n && !i_oe_n;
  assign o_rdy = !busy;
  initial foreach (mem[i]) mem[i] = 16'hffff;
  task automatic go(input int m, input int c);
    // top quarter of the array is a protected sector
    if (m == 2) foreach (mem[i]) if (i < 192) mem[i] = 16'hffff;
    mode = m;
    cnt = c;
  endtask
  // ==========================================
  // read path: released bus shows inverse of last value
  always_comb
    if (rd) o_dq = cfi ? 16'h0051 : !busy ? mem[i_addr[7:0]] :
      {pd[15:8], mode == 1 && !pd[7], tog, 2'b0, mode != 3, tog,
      2'b0};
    else o_dq = ~last;
  // ==========================================
  // command decoder and embedded timers
  always @(posedge i_clock) begin
    we_q <= i_we_n;
    oe_q <= i_oe_n;
    if (rd) last <= o_dq;
    if (oe_q && !i_oe_n && busy) tog <= ~tog;
    if (cnt > 0) cnt = cnt - 1;
    else if (mode == 3) go(2, ERA);
    else if (mode == 4) go(5, 0);
    else if (mode == 1 || mode == 2) go(0, 0);
    if (i_we_n && !we_q && !i_ce_n) begin
      if (mode == 2 && !chip && d == 8'hb0) go(4, REC);
      else if (busy && mode != 3) step = 0;
      else if (mode == 3 && d == 8'hb0) go(5, 0);
      else if (mode == 5 && step == 0 && d == 8'h30) go(2, ERA);
      else if (d == 8'hf0) begin
        cfi = 0;
        step = 0;
        if (mode == 3) go(0, 0);
      end else if (step == 0 && d == 8'h98 && i_addr == cfa) cfi = 1;
      else if (step == 6) begin
        if (i_addr[7:6] != 2'b11)
          mem[i_addr[7:0]] = mem[i_addr[7:0]] & i_dq;
        pd = i_dq;
        step = 0;
        go(1, i_addr[7:6] == 2'b11 ? ABT : PROG);
      end else if (step == 0 || step == 3)
        step = d == 8'haa && i_addr == u1 ? step + 1 : 0;
      else if (step == 1 || step == 4)
        step = d == 8'h55 && i_addr == u2 ? step + 1 : 0;
      else if (step == 2) step = d == 8'ha0 ? 6 : d == 8'h80 ? 3 : 0;
      else begin
        step = 0;
        chip = d == 8'h10;
        if (chip) go(2, ERA);
        else if (d == 8'h30) go(3, WIN);
      end
    end
  end
endmodule

/* File: test/tb_nor_flash_program_erase_sequencer.sv */
// self-checking bench for the flash command controller
`timescale 1ns/10ps
`include "nfps_map.vh"
module tb_nor_flash_program_erase_sequencer;
  localparam int WIN = 600;
  logic i_clock = 0, i_rst_b = 0, rd = 0, wr = 0;
  logic [3:0] ad = 4'h0;
  logic [31:0] wd = 32'h0, rq, q;
  logic wq, dq_oe, ce_n, we_n, oe_n, byte_n, rdy;
  logic [20:0] fa;
  logic [15:0] dq_o, fm_dq, v;
  wire [15:0] dq = dq_oe ? dq_o : fm_dq;
  int miscompares = 0, check_count = 0, cyc = 0;
  always #2 i_clock = ~i_clock;
  nfps_ctrl dut_u (.i_clock(i_clock), .i_rst_b(i_rst_b),
    .i_avs_address(ad), .i_avs_read(rd), .i_avs_write(wr),
    .i_avs_writedata(wd), .o_avs_readdata(rq), .o_avs_waitrequest(wq),
    .o_fl_addr(fa), .i_fl_dq(dq), .o_fl_dq(dq_o), .o_fl_dq_oe(dq_oe),
    .o_fl_ce_n(ce_n), .o_fl_we_n(we_n), .o_fl_oe_n(oe_n),
    .o_fl_byte_n(byte_n), .i_fl_ready_busy_n(rdy));
  nfps_flash_model #(.WIN(WIN)) flash_u (.i_clock(i_clock), .i_addr(fa),
    .i_dq(dq), .i_ce_n(ce_n), .i_we_n(we_n), .i_oe_n(oe_n),
    .i_byte_n(byte_n), .o_dq(fm_dq), .o_rdy(rdy));
  // ==========================================
  // shared tasks
  task report_and_stop;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %0t got %h expected %h", $time, g, e);
    end
  endtask
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    rd <= !w;
    wr <= w;
    ad <= a;
    wd <= d;
    do @(posedge i_clock); while (wq !== 1'b0);
    q = rq;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge i_clock);
  endtask
  task op(input logic [2:0] c, input logic b, input logic [20:0] a,
    input logic [15:0] d);
    bus(1, `NFPS_REG_ADDR, {11'h0, a});
    bus(1, `NFPS_REG_DATA, {16'h0, d});
    bus(1, `NFPS_REG_CTRL, {21'h0, c, 3'h0, b, 3'h0, 1'b1});
    q = 32'h1;
    while (q[0] !== 1'b0) bus(0, `NFPS_REG_CTRL, 32'h0);
  endtask
  task fget(input logic b, input logic [20:0] a);
    op(`NFPS_OP_READ, b, a, 16'h0);
    bus(0, `NFPS_REG_DATA, 32'h0);
    v = q[15:0];
  endtask
  task idle;
    q = 32'h0;
    while (q[1] !== 1'b1) bus(0, `NFPS_REG_STAT, 32'h0);
  endtask
  // ==========================================
  // scenarios
  task t_regs;
    bus(0, `NFPS_REG_CTRL, 32'h0);
    chk(q, `NFPS_RST_CTRL);
    bus(1, 4'h1, 32'hffffffff);
    bus(0, 4'h1, 32'h0);
    chk(q, 32'h0);
  endtask
  task t_prog;
    op(`NFPS_OP_PROG, 0, 21'h10, 16'h1234);
    bus(0, `NFPS_REG_STAT, 32'h0);
    chk(32'(q[1]), 32'h0);
    chk(32'(q[2]), 32'h1);
    fget(0, 21'h10);
    chk(32'(v[7]), 32'h1);
    fget(0, 21'h10);
    bus(0, `NFPS_REG_STAT, 32'h0);
    chk(32'(q[3]), 32'h1);
    idle;
    fget(0, 21'h10);
    chk(32'(v), 32'h1234);
    op(`NFPS_OP_PROG, 0, 21'h10, 16'hff00);
    idle;
    fget(0, 21'h10);
    chk(32'(v), 32'h1200);
    chk(32'(q[31:16]), 32'h1234);
    op(`NFPS_OP_PROG, 0, 21'hc0, 16'h0000);
    idle;
    fget(0, 21'hc0);
    chk(32'(v), 32'hffff);
    op(`NFPS_OP_PROG, 1, 21'h21, 16'h00a5);
    idle;
    fget(1, 21'h21);
    chk(32'(v[7:0]), 32'ha5);
    chk(32'(byte_n), 32'h0);
  endtask
  task t_chip;
    op(`NFPS_OP_CHIP, 0, 21'h0, 16'h0);
    op(`NFPS_OP_SUSP, 0, 21'h0, 16'h0);
    bus(0, `NFPS_REG_STAT, 32'h0);
    chk(32'(q[1]), 32'h0);
    fget(0, 21'h10);
    chk(32'(v[7]), 32'h0);
    idle;
    fget(0, 21'h10);
    chk(32'(v), 32'hffff);
  endtask
  task t_sect;
    op(`NFPS_OP_SECT, 0, 21'h40, 16'h0);
    fget(0, 21'h40);
    chk(32'(v[3]), 32'h0);
    op(`NFPS_OP_SECT, 0, 21'h80, 16'h0);
    repeat (WIN - 150) @(posedge i_clock);
    fget(0, 21'h40);
    chk(32'(v[3]), 32'h0);
    repeat (WIN) @(posedge i_clock);
    fget(0, 21'h40);
    chk(32'(v[3]), 32'h1);
    op(`NFPS_OP_SUSP, 0, 21'h0, 16'h0);
    idle;
    fget(0, 21'h10);
    chk(32'(v), 32'hffff);
    op(`NFPS_OP_RESM, 0, 21'h0, 16'h0);
    bus(0, `NFPS_REG_STAT, 32'h0);
    chk(32'(q[1]), 32'h0);
    idle;
    op(`NFPS_OP_SECT, 0, 21'h40, 16'h0);
    op(`NFPS_OP_RST, 0, 21'h0, 16'h0);
    bus(0, `NFPS_REG_STAT, 32'h0);
    chk(32'(q[1]), 32'h1);
  endtask
  task t_cfi;
    for (int b = 0; b < 2; b++) begin
      op(`NFPS_OP_CFI, b[0], 21'h0, 16'h0);
      fget(b[0], 21'h10);
      chk(32'(v), 32'h51);
      op(`NFPS_OP_RST, b[0], 21'h0, 16'h0);
    end
    fget(0, 21'h10);
    chk(32'(v), 32'hffff);
  endtask
  always @(posedge i_clock) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      miscompares++;
      report_and_stop;
    end
  end
  initial begin
    repeat (16) @(posedge i_clock);
    i_rst_b <= 1'b1;
    @(posedge i_clock);
    t_regs;
    t_prog;
    t_chip;
    t_sect;
    t_cfi;
    report_and_stop;
  end
endmodule
